// ---- rtl/pd_handshake_pkg.sv ----
package pd_handshake_pkg;

    // ------------------------------------------------------------
    // register indices (word index; byte address is four times it)
    // ------------------------------------------------------------
    localparam logic [11:0] RX_CONN_CTRL_IDX = 12'h3e8;
    localparam logic [11:0] RX_IO_CTRL_IDX = 12'h3e9;
    localparam logic [11:0] RX_DATA_IDX = 12'h3ea;
    localparam logic [11:0] TX_CONN_CTRL_IDX = 12'h7d0;
    localparam logic [11:0] TX_IO_STATUS_IDX = 12'h7d1;
    localparam logic [11:0] TX_DATA_IDX = 12'h7d2;
    localparam logic [11:0] PHASE_STATUS_IDX = 12'h7f0;

    // ------------------------------------------------------------
    // field positions and fixed values
    // ------------------------------------------------------------
    localparam int PRODUCER_READY_BIT = 0;
    localparam int NEW_DATA_BIT = 1;
    localparam int BUS_SYNC_BIT = 3;
    localparam int OUTPUT_STATE_BIT = 15;
    localparam int OUTPUTS_READY_BIT = 15;
    localparam int INPUTS_VALID_BIT = 14;
    localparam logic [15:0] IO_CTRL_ACTIVE = 16'h8000;
    localparam logic [15:0] IO_CTRL_INACTIVE = 16'h0000;
    localparam logic [15:0] CONN_CTRL_RESET = 16'h0008;
    localparam logic [15:0] TX_CONN_WMASK = 16'h0001;
    localparam logic [15:0] IO_STATUS_WMASK = 16'hc000;
    localparam logic [15:0] IO_STATUS_RESET = 16'h0000;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    // one accepted master telegram
    typedef struct packed {
        logic [15:0] io_control;
        logic [15:0] data0;
        logic [15:0] data1;
    } rx_telegram_t;

    // word handed to the slave-to-master telegram
    typedef struct packed {
        logic [15:0] conn_control;
        logic [15:0] io_status;
        logic [15:0] data0;
        logic [15:0] data1;
        logic enable;
    } tx_telegram_t;

endpackage

// ---- rtl/fieldbus_process_data_handshake.sv ----
// Operation
// - mirror connection control words at register 1000 (receive) and 2000 (transmit)
// - bit 3 of both connection control words always reads 1
// - each new master telegram in phase CP4 sets producer ready bit 0
// - new-data toggle bit cleared on entering phase CP4
// - new-data toggle inverted on receive when carried data change, on transmit when host-written data go out in a slot
// - io control word from master telegrams mirrored at register 1001
// - io control keeps only bit 15; value is 0x8000 or 0x0000
// - slave output data forwarded to master only while io control is 0x8000
// - host-written io status word mirrored at register 2001
// - transmit new-data bit 1 is toggled by the device itself
//
// The APB slave port was chosen for this implementation.
module fieldbus_process_data_handshake
    import pd_handshake_pkg::*;
#(
    parameter int DATA_WORDS = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_in_cp4,
    input wire logic rx_valid,
    input wire rx_telegram_t rx_telegram,
    input wire logic tx_slot,
    output tx_telegram_t tx_telegram
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // the mirror logic names both data words one by one
    if (DATA_WORDS != 2) begin : g_bad_words
        $error("DATA_WORDS must be 2");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // gray codes along init to cp4; the link may drop back at any time
    typedef enum logic [1:0] {
        PH_INIT = 2'b00,
        PH_CP4 = 2'b01
    } phase_t;

    // register and next-value pairs
    phase_t phase_reg, phase_next;
    logic [15:0] rx_conn_reg, rx_conn_next;
    logic [15:0] rx_ioc_reg, rx_ioc_next;
    logic [15:0] rx_d0_reg, rx_d0_next;
    logic [15:0] rx_d1_reg, rx_d1_next;
    logic [15:0] tx_conn_reg, tx_conn_next;
    logic [15:0] tx_ios_reg, tx_ios_next;
    logic [15:0] tx_d0_reg, tx_d0_next;
    logic [15:0] tx_d1_reg, tx_d1_next;
    logic tx_dirty_reg, tx_dirty_next;
    logic [31:0] prdata_next;
    logic pslverr_next;
    tx_telegram_t tx_tel_next;
    logic pready_next;

    // merge a 16-bit register with byte strobes and a write mask
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb, input logic [15:0] mask);
        logic [15:0] lane;
        lane = {{8{strb[1]}}, {8{strb[0]}}} & mask;
        return (old & ~lane) | (wd[15:0] & lane);
    endfunction

    // ------------------------------------------------------------
    // bus decode: one wait state in every access
    // ------------------------------------------------------------
    wire [11:0] word_idx = paddr[13:2];
    wire access = psel & penable;
    // first access edge latches the answer, the second completes it
    wire wait_phase = access & ~pready;
    wire done = access & pready;
    wire wr = done & pwrite;
    // one hit per mapped word
    wire hit_rx_conn = word_idx == RX_CONN_CTRL_IDX;
    wire hit_rx_ioc = word_idx == RX_IO_CTRL_IDX;
    wire hit_rx_d0 = word_idx == RX_DATA_IDX;
    wire hit_rx_d1 = word_idx == RX_DATA_IDX + 12'h001;
    wire hit_tx_conn = word_idx == TX_CONN_CTRL_IDX;
    wire hit_tx_ios = word_idx == TX_IO_STATUS_IDX;
    wire hit_tx_d0 = word_idx == TX_DATA_IDX;
    wire hit_tx_d1 = word_idx == TX_DATA_IDX + 12'h001;
    wire hit_phase = word_idx == PHASE_STATUS_IDX;
    // aliases refused: a stray upper bit would hide a host fault
    wire aligned = paddr[1:0] == 2'b00 && paddr[31:14] == 18'h0;
    wire mapped = aligned & (hit_rx_conn | hit_rx_ioc | hit_rx_d0 | hit_rx_d1 | hit_tx_conn
                             | hit_tx_ios | hit_tx_d0 | hit_tx_d1 | hit_phase);
    // link-side events
    wire entering_cp4 = link_in_cp4 && phase_reg == PH_INIT;
    wire accept_rx = rx_valid && link_in_cp4;
    wire outputs_on = rx_ioc_reg == IO_CTRL_ACTIVE;

    // write strobes; only the completing edge of an access takes effect
    wire wr_tx_conn = wr & aligned & hit_tx_conn;
    wire wr_tx_ios = wr & aligned & hit_tx_ios;
    wire wr_tx_d0 = wr & aligned & hit_tx_d0;
    wire wr_tx_d1 = wr & aligned & hit_tx_d1;
    wire wr_tx_data = wr_tx_d0 | wr_tx_d1;
    // receive words and phase status are read-only for the host
    wire hit_read_only = hit_rx_conn | hit_rx_ioc | hit_rx_d0 | hit_rx_d1 | hit_phase;
    // fresh output data leave only in a slot with active outputs
    wire tx_send = tx_slot & tx_dirty_reg & outputs_on;

    // phase tracking of the slave state machine
    always_comb begin
        phase_next = link_in_cp4 ? PH_CP4 : PH_INIT;
    end

    // received-direction mirror; all words load in the same edge
    always_comb begin
        rx_conn_next = rx_conn_reg;
        rx_ioc_next = rx_ioc_reg;
        rx_d0_next = rx_d0_reg;
        rx_d1_next = rx_d1_reg;
        if (entering_cp4) begin
            rx_conn_next[NEW_DATA_BIT] = 1'b0;
        end
        if (accept_rx) begin
            rx_conn_next[PRODUCER_READY_BIT] = 1'b1;
            // the master is the producer here; data change flips the toggle
            if (rx_telegram.data0 != rx_d0_reg || rx_telegram.data1 != rx_d1_reg) begin
                rx_conn_next[NEW_DATA_BIT] = ~rx_conn_next[NEW_DATA_BIT];
            end
            rx_ioc_next = rx_telegram.io_control & IO_CTRL_ACTIVE;
            rx_d0_next = rx_telegram.data0;
            rx_d1_next = rx_telegram.data1;
        end else if (!link_in_cp4) begin
            rx_conn_next[PRODUCER_READY_BIT] = 1'b0;
        end
        rx_conn_next[BUS_SYNC_BIT] = 1'b1;
    end

    // transmit-direction words written by the host
    always_comb begin
        tx_conn_next = tx_conn_reg;
        tx_ios_next = tx_ios_reg;
        tx_d0_next = tx_d0_reg;
        tx_d1_next = tx_d1_reg;
        // stack toggles the new-data flag when fresh output data go out
        if (tx_send) begin
            tx_conn_next[NEW_DATA_BIT] = ~tx_conn_reg[NEW_DATA_BIT];
        end
        if (entering_cp4) begin
            tx_conn_next[NEW_DATA_BIT] = 1'b0;
        end
        // host writes merge into the next value, so a same-edge toggle survives
        if (wr_tx_conn) begin
            tx_conn_next = merge16(tx_conn_next, pwdata, pstrb, TX_CONN_WMASK);
        end
        if (wr_tx_ios) begin
            tx_ios_next = merge16(tx_ios_reg, pwdata, pstrb, IO_STATUS_WMASK);
        end
        if (wr_tx_d0) begin
            tx_d0_next = merge16(tx_d0_reg, pwdata, pstrb, 16'hffff);
        end
        if (wr_tx_d1) begin
            tx_d1_next = merge16(tx_d1_reg, pwdata, pstrb, 16'hffff);
        end
        tx_conn_next[BUS_SYNC_BIT] = 1'b1;
    end

    // pending output data; a host write in the sending edge wins over the clear
    always_comb begin
        tx_dirty_next = tx_dirty_reg;
        if (tx_send) begin
            tx_dirty_next = 1'b0;
        end
        if (wr_tx_data) begin
            tx_dirty_next = 1'b1;
        end
    end

    // read data selection
    always_comb begin
        prdata_next = 32'h0;
        if (wait_phase && !pwrite && mapped) begin
            unique case (1'b1)
                hit_rx_conn: prdata_next[15:0] = rx_conn_reg;
                hit_rx_ioc: prdata_next[15:0] = rx_ioc_reg;
                hit_rx_d0: prdata_next[15:0] = rx_d0_reg;
                hit_rx_d1: prdata_next[15:0] = rx_d1_reg;
                hit_tx_conn: prdata_next[15:0] = tx_conn_reg;
                hit_tx_ios: prdata_next[15:0] = tx_ios_reg;
                hit_tx_d0: prdata_next[15:0] = tx_d0_reg;
                hit_tx_d1: prdata_next[15:0] = tx_d1_reg;
                hit_phase: prdata_next[0] = phase_reg == PH_CP4;
                default: prdata_next = 32'h0;
            endcase
        end
        // receive side is read-only: a write there is an error
        pslverr_next = wait_phase && (!mapped || (pwrite && hit_read_only));
    end

    // outgoing telegram; data only forwarded with active outputs
    always_comb begin
        tx_tel_next.conn_control = tx_conn_reg;
        tx_tel_next.io_status = tx_ios_reg;
        tx_tel_next.data0 = outputs_on ? tx_d0_reg : WORD_RESET;
        tx_tel_next.data1 = outputs_on ? tx_d1_reg : WORD_RESET;
        tx_tel_next.enable = outputs_on;
    end

    // one wait state: ready rises after the first access edge, falls after the second
    always_comb begin
        pready_next = wait_phase;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // phase of the slave state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= PH_INIT;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // received mirror; one edge loads the whole set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_conn_reg <= CONN_CTRL_RESET;
            rx_ioc_reg <= IO_CTRL_INACTIVE;
            rx_d0_reg <= WORD_RESET;
            rx_d1_reg <= WORD_RESET;
        end else begin
            rx_conn_reg <= rx_conn_next;
            rx_ioc_reg <= rx_ioc_next;
            rx_d0_reg <= rx_d0_next;
            rx_d1_reg <= rx_d1_next;
        end
    end

    // host-written transmit words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_conn_reg <= CONN_CTRL_RESET;
            tx_ios_reg <= IO_STATUS_RESET;
            tx_d0_reg <= WORD_RESET;
            tx_d1_reg <= WORD_RESET;
        end else begin
            tx_conn_reg <= tx_conn_next;
            tx_ios_reg <= tx_ios_next;
            tx_d0_reg <= tx_d0_next;
            tx_d1_reg <= tx_d1_next;
        end
    end

    // pending output data flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_dirty_reg <= 1'b0;
        end else begin
            tx_dirty_reg <= tx_dirty_next;
        end
    end

    // bus answer; read data and error stand only at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= prdata_next;
            pready <= pready_next;
            pslverr <= pslverr_next;
        end
    end

    // outgoing telegram; registered so the link side sees no decode glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_telegram <= '0;
        end else begin
            tx_telegram <= tx_tel_next;
        end
    end

endmodule

// ---- tb/pd_handshake_properties.sv ----
// ----
// handshake checker
// ----
module pd_handshake_properties
    import pd_handshake_pkg::*;
#(
    parameter int DATA_WORDS = 2
) (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [31:0] paddr,
    input logic [31:0] pwdata,
    input logic [3:0] pstrb,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic link_in_cp4,
    input logic rx_valid,
    input rx_telegram_t rx_telegram,
    input logic tx_slot,
    input tx_telegram_t tx_telegram
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // completing access edge: ready high, read data and error stand here
    sequence s_acc(logic [31:0] a, logic w);
        psel && penable && pready && pwrite == w && paddr == a;
    endsequence
    sequence s_take;
        rx_valid && link_in_cp4;
    endsequence
    AST_RX_SYNC_BIT: assert property (s_acc(32'h0000_0fa0, 1'b0) |-> prdata[3])
        else $error("sync bit low on read");
    AST_TX_SYNC_BIT: assert property ($past(presetn) |-> tx_telegram.conn_control[3])
        else $error("sync bit low in telegram");
    AST_RO_REFUSED: assert property (s_acc(32'h0000_0fa4, 1'b1) |-> pslverr)
        else $error("write to io control accepted");
    AST_IO_CTRL_FORM: assert property (s_acc(32'h0000_0fa4, 1'b0)
        |-> !(|(prdata & 32'hffff_7fff)))
        else $error("io control has stray bits");
    AST_IO_STATUS_FORM: assert property (s_acc(32'h0000_1f44, 1'b0)
        |-> !(|(prdata & 32'hffff_3fff)))
        else $error("io status has stray bits");
    AST_FWD_OFF: assert property ((s_take and !rx_telegram.io_control[15])
        |-> ##2 !tx_telegram.enable)
        else $error("forwarding while outputs inactive");
    AST_FWD_ON: assert property ((s_take and rx_telegram.io_control[15])
        |-> ##2 tx_telegram.enable)
        else $error("no forwarding while outputs active");
    AST_TX_TOGGLE_CAUSE: assert property ($changed(tx_telegram.conn_control[1])
        |-> $past(tx_slot, 2) || ($past(link_in_cp4, 2) && !$past(link_in_cp4, 3)))
        else $error("transmit toggle without cause");
endmodule

bind fieldbus_process_data_handshake pd_handshake_properties #(.DATA_WORDS(DATA_WORDS)) props_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_in_cp4(link_in_cp4), .rx_valid(rx_valid),
    .rx_telegram(rx_telegram), .tx_slot(tx_slot), .tx_telegram(tx_telegram));

// ---- tb/fieldbus_master_model.sv ----
// ----
// fieldbus master stand-in
// ----
module fieldbus_master_model
    import pd_handshake_pkg::*;
(
    input logic pclk,
    output logic link_in_cp4,
    output logic rx_valid,
    output rx_telegram_t rx_telegram,
    output logic tx_slot
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        link_in_cp4 = 1'b0;
        rx_valid = 1'b0;
        rx_telegram = '0;
        tx_slot = 1'b0;
    end
    task automatic set_cp4(input logic on);
        @(posedge pclk);
        link_in_cp4 <= on;
    endtask
    // payload inverted after the pulse so stale data never looks valid
    task automatic send(input logic [15:0] io, input logic [15:0] d0, input logic [15:0] d1);
        @(posedge pclk);
        rx_valid <= 1'b1;
        rx_telegram <= {io, d0, d1};
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_telegram <= ~{io, d0, d1};
    endtask
    task automatic slot();
        @(posedge pclk);
        tx_slot <= 1'b1;
        @(posedge pclk);
        tx_slot <= 1'b0;
    endtask
endmodule

// ---- tb/tb_fieldbus_process_data_handshake.sv ----
module tb_fieldbus_process_data_handshake import pd_handshake_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
    logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
    logic link_in_cp4, rx_valid, tx_slot;
    rx_telegram_t rx_telegram;
    tx_telegram_t tx_telegram;
    int n_mismatch = 0, compares = 0;
    always #12.5 pclk = ~pclk;
    fieldbus_process_data_handshake fieldbus_process_data_handshake_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link_in_cp4(link_in_cp4), .rx_valid(rx_valid),
        .rx_telegram(rx_telegram), .tx_slot(tx_slot), .tx_telegram(tx_telegram));
    fieldbus_master_model fieldbus_master_model_i (.pclk(pclk), .link_in_cp4(link_in_cp4),
        .rx_valid(rx_valid), .rx_telegram(rx_telegram), .tx_slot(tx_slot));
    // ----
    // bus tasks
    // ----
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // request held until ready is seen high; answer taken at that same edge
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string n, input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(n, exp, rd);
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        report_and_stop();
    end
    // ----
    // tests
    // ----
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("rx conn", 32'hfa0, 32'h8);
        check("read err", 32'h0, 32'(er));
        rdchk("tx conn", 32'h1f40, 32'h8);
        apb(1'b1, 32'hfa4, 32'hffff);
        check("ro write err", 32'h1, 32'(er));
        apb(1'b0, 32'h100, 32'h0);
        check("unmapped err", 32'h1, 32'(er));
        fieldbus_master_model_i.send(16'hffff, 16'h1234, 16'h5678);
        rdchk("outside cp4", 32'hfa8, 32'h0);
        fieldbus_master_model_i.set_cp4(1'b1);
        fieldbus_master_model_i.send(16'hffff, 16'h1234, 16'h5678);
        rdchk("rx conn", 32'hfa0, 32'hb);
        rdchk("io ctrl", 32'hfa4, 32'h8000);
        rdchk("data0", 32'hfa8, 32'h1234);
        rdchk("data1", 32'hfac, 32'h5678);
        fieldbus_master_model_i.send(16'h8000, 16'h1234, 16'h5678);
        rdchk("same data", 32'hfa0, 32'hb);
        apb(1'b1, 32'h1f48, 32'haaaa);
        apb(1'b1, 32'h1f4c, 32'h5555);
        apb(1'b1, 32'h1f44, 32'hffff);
        apb(1'b1, 32'h1f40, 32'hffff);
        rdchk("io status", 32'h1f44, 32'hc000);
        rdchk("tx conn", 32'h1f40, 32'h9);
        fieldbus_master_model_i.slot();
        repeat (2) @(posedge pclk);
        check("tx conn out", 32'hb, 32'(tx_telegram.conn_control));
        check("tx data out", 32'haaaa, 32'(tx_telegram.data0));
        check("tx data1 out", 32'h5555, 32'(tx_telegram.data1));
        check("tx status out", 32'hc000, 32'(tx_telegram.io_status));
        check("tx enable", 32'h1, 32'(tx_telegram.enable));
        fieldbus_master_model_i.set_cp4(1'b0);
        fieldbus_master_model_i.set_cp4(1'b1);
        rdchk("cp4 entry rx", 32'hfa0, 32'h8);
        rdchk("cp4 entry tx", 32'h1f40, 32'h9);
        rdchk("phase", 32'h1fc0, 32'h1);
        fieldbus_master_model_i.send(16'h0000, 16'h0001, 16'h0002);
        rdchk("new data", 32'hfa0, 32'hb);
        rdchk("io off", 32'hfa4, 32'h0);
        check("fwd off", 32'h0, 32'(tx_telegram.enable));
        check("fwd off data", 32'h0, 32'(tx_telegram.data0));
        fieldbus_master_model_i.send(16'h8000, 16'h0003, 16'h0004);
        fieldbus_master_model_i.send(16'h8000, 16'h0005, 16'h0006);
        rdchk("two toggles", 32'hfa0, 32'hb);
        rdchk("latest data0", 32'hfa8, 32'h5);
        rdchk("latest data1", 32'hfac, 32'h6);
        report_and_stop();
    end
endmodule
